/* File: logic/cnt_pkg.sv */
package cnt_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W_DOC = 32;

  // Register map, byte addresses
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;

  // Control register fields
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DOWN_BIT = 1;
  localparam int CTRL_RST_BIT = 2;
  localparam int CTRL_CLR_BIT = 3;
  localparam logic CTRL_EN_RST = 1'h1;
  localparam logic CTRL_DOWN_RST = 1'h0;

  // Status register fields
  localparam int ST_OVF_BIT = 0;
  localparam int ST_CARRY_BIT = 1;
  localparam int ST_EN_BIT = 2;
  localparam int ST_DOWN_BIT = 3;

  // Interrupt events
  localparam int IRQ_W = 3;
  localparam int IRQ_TERM_BIT = 0;
  localparam int IRQ_SAT_BIT = 1;
  localparam int IRQ_RST_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // Sampled pins
  localparam int NUM_PINS = 4;
  localparam int PIN_CLK = 0;
  localparam int PIN_EN = 1;
  localparam int PIN_RST = 2;
  localparam int PIN_CLR = 3;
endpackage

/* File: logic/sample_if.sv */
interface sample_if #(parameter int N = 4);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

/* File: logic/pin_sampler.sv */
module pin_sampler #(
  parameter int N = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [N-1:0] pins,
  sample_if.src smp
);
  logic [N-1:0] s1_q;
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;
  logic [N-1:0] filt_q;
  logic [N-1:0] prev_q;

  if (N < 1) begin : g_chk
    $error("pin_sampler needs at least one pin");
  end

  for (genvar i = 0; i < N; i++) begin : g_pin
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        s1_q[i] <= 1'h0;
        s2_q[i] <= 1'h0;
        s3_q[i] <= 1'h0;
      end else begin
        s1_q[i] <= pins[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
      end
    end

    // Accept a new level only once two stages agree
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        filt_q[i] <= 1'h0;
        prev_q[i] <= 1'h0;
      end else begin
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
        prev_q[i] <= filt_q[i];
      end
    end

    a_edge_compare: assert property (
      @(posedge clk) disable iff (!arst_n)
      smp.rise[i] |-> (filt_q[i] && !$past(filt_q[i])))
      else $error("rise without a 0 to 1 change of the sample");
  end

  assign smp.level = filt_q;
  assign smp.rise = filt_q & ~prev_q;
endmodule

/* File: logic/event_counter.sv */
module event_counter
  import cnt_pkg::*;
#(
  parameter int CNT_W = CNT_W_DOC,
  parameter logic [CNT_W-1:0] TARGET_RST = 32'h0000_FFFF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cnt_clk_in,
  input wire logic cnt_en_in,
  input wire logic cnt_rst_in,
  input wire logic cnt_clr_in,
  output logic [CNT_W-1:0] count,
  output logic overflow,
  output logic carry,
  output logic irq,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata
);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  if (CNT_W < 2 || CNT_W > DATA_W) begin : g_chk
    $error("event_counter: CNT_W must lie in 2..DATA_W");
  end

  logic [NUM_PINS-1:0] pins;
  logic ctrl_en_q;
  logic ctrl_down_q;
  logic [CNT_W-1:0] target_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic ovf_q;
  logic carry_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;
  logic wr_ctrl;
  logic wr_irq_stat;
  logic sw_rst;
  logic sw_clr;
  logic en_eff;
  logic rst_any;
  logic clr_any;
  logic step;
  logic [CNT_W-1:0] term_val;
  logic at_term;
  logic sat_ev;
  logic term_ev;
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] irq_w1c;

  sample_if #(.N(NUM_PINS)) smp ();

  assign pins[PIN_CLK] = cnt_clk_in;
  assign pins[PIN_EN] = cnt_en_in;
  assign pins[PIN_RST] = cnt_rst_in;
  assign pins[PIN_CLR] = cnt_clr_in;

  pin_sampler #(.N(NUM_PINS)) u_sampler (
    .clk(clk),
    .arst_n(arst_n),
    .pins(pins),
    .smp(smp)
  );

  // Register bus decode
  assign wr_ctrl = wr && (addr == OFS_CTRL);
  assign wr_irq_stat = wr && (addr == OFS_IRQ_STAT);
  assign sw_rst = wr_ctrl && wdata[CTRL_RST_BIT];
  assign sw_clr = wr_ctrl && wdata[CTRL_CLR_BIT];

  // Enable pin may be a carry from the previous stage
  assign en_eff = smp.level[PIN_EN] && ctrl_en_q;
  assign rst_any = smp.level[PIN_RST] || sw_rst;
  assign clr_any = smp.level[PIN_CLR] || sw_clr;
  assign step = en_eff && smp.rise[PIN_CLK];

  assign term_val = ctrl_down_q ? CNT_ZERO : target_q;
  assign at_term = (count_q == term_val);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_en_q <= CTRL_EN_RST;
      ctrl_down_q <= CTRL_DOWN_RST;
    end else if (wr_ctrl) begin
      ctrl_en_q <= wdata[CTRL_EN_BIT];
      ctrl_down_q <= wdata[CTRL_DOWN_BIT];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      target_q <= TARGET_RST;
    end else if (wr && (addr == OFS_TARGET)) begin
      target_q <= wdata[CNT_W-1:0];
    end
  end

  // Next count
  always_comb begin
    count_d = count_q;
    if (rst_any) begin
      count_d = ctrl_down_q ? target_q : CNT_ZERO;
    end else if (step) begin
      if (ctrl_down_q) begin
        if (count_q != CNT_ZERO) begin
          count_d = count_q - CNT_ONE;
        end
      end else if (count_q != CNT_MAX) begin
        count_d = count_q + CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_q <= CNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  // Sticky terminal flag; reset clears first, terminal beats a clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= 1'h0;
    end else if (rst_any) begin
      ovf_q <= 1'h0;
    end else if (at_term) begin
      ovf_q <= 1'h1;
    end else if (clr_any) begin
      ovf_q <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carry_q <= 1'h0;
    end else begin
      carry_q <= en_eff && at_term;
    end
  end

  // Interrupt status: set wins over write-one-to-clear
  assign term_ev = at_term && !ovf_q;
  assign sat_ev = step && !ctrl_down_q && !rst_any && (count_q == CNT_MAX);
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_TERM_BIT] = term_ev;
    irq_ev[IRQ_SAT_BIT] = sat_ev;
    irq_ev[IRQ_RST_BIT] = rst_any;
  end
  assign irq_w1c = wr_irq_stat ? wdata[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_w1c) | irq_ev;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_mask_q <= IRQ_MASK_RST;
    end else if (wr && (addr == OFS_IRQ_MASK)) begin
      irq_mask_q <= wdata[IRQ_W-1:0];
    end
  end

  // Read mux; unmapped and idle cycles return zero
  always_comb begin
    rdata_d = '0;
    if (rd) begin
      unique case (addr)
        OFS_CTRL: begin
          rdata_d[CTRL_EN_BIT] = ctrl_en_q;
          rdata_d[CTRL_DOWN_BIT] = ctrl_down_q;
        end
        OFS_TARGET: begin
          rdata_d[CNT_W-1:0] = target_q;
        end
        OFS_COUNT: begin
          rdata_d[CNT_W-1:0] = count_q;
        end
        OFS_STATUS: begin
          rdata_d[ST_OVF_BIT] = ovf_q;
          rdata_d[ST_CARRY_BIT] = carry_q;
          rdata_d[ST_EN_BIT] = en_eff;
          rdata_d[ST_DOWN_BIT] = ctrl_down_q;
        end
        OFS_IRQ_STAT: begin
          rdata_d[IRQ_W-1:0] = irq_stat_q;
        end
        OFS_IRQ_MASK: begin
          rdata_d[IRQ_W-1:0] = irq_mask_q;
        end
        default: begin
          rdata_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign count = count_q;
  assign overflow = ovf_q;
  assign carry = carry_q;
  assign irq = |(irq_stat_q & irq_mask_q);
  assign rdata = rdata_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  a_single_step: assert property (
    !rst_any |=> (count_q == $past(count_q))
      || (count_q == $past(count_q) + CNT_ONE)
      || (count_q == $past(count_q) - CNT_ONE))
    else $error("count moved by more than one");

  a_step_up: assert property (
    step && !ctrl_down_q && !rst_any && count_q != CNT_MAX
    |=> count_q == $past(count_q) + CNT_ONE)
    else $error("up edge did not increment");

  a_step_down: assert property (
    step && ctrl_down_q && !rst_any && count_q != CNT_ZERO
    |=> count_q == $past(count_q) - CNT_ONE)
    else $error("down edge did not decrement");

  a_reset_load: assert property (
    rst_any |=> count_q == ($past(ctrl_down_q) ? $past(target_q)
      : CNT_ZERO))
    else $error("reset loaded wrong value");

  a_frozen_count: assert property (
    !en_eff && !rst_any |=> $stable(count_q))
    else $error("count moved while disabled");

  a_carry_cause: assert property (
    carry_q |-> $past(en_eff) && $past(count_q) == $past(term_val))
    else $error("carry without enable at terminal");

  a_flag_sets: assert property (
    at_term && !rst_any |=> ovf_q)
    else $error("terminal flag not set");

  a_flag_clear: assert property (
    clr_any && !rst_any && !at_term && !step
    |=> !ovf_q && $stable(count_q))
    else $error("flag clear failed or touched count");

  a_no_underflow: assert property (
    ctrl_down_q && count_q == CNT_ZERO && !rst_any |=> count_q == CNT_ZERO)
    else $error("count went below zero");

  a_irq_sticky: assert property (
    irq_stat_q[IRQ_TERM_BIT] && !wr_irq_stat |=> irq_stat_q[IRQ_TERM_BIT])
    else $error("interrupt status lost");

  a_carry_at_term: assert property (
    en_eff && at_term |=> carry_q)
    else $error("carry missing at terminal");

  a_carry_off_idle: assert property (
    !en_eff |=> !carry_q)
    else $error("carry while disabled");

  a_flag_rst_clear: assert property (
    rst_any |=> !ovf_q)
    else $error("reset left flag set");

  a_flag_holds: assert property (
    ovf_q && !rst_any && !clr_any |=> ovf_q)
    else $error("flag dropped without clear");

  a_clear_keeps_count: assert property (
    clr_any && !rst_any && !step |=> $stable(count_q))
    else $error("flag clear moved count");

  a_idle_no_move: assert property (
    !step && !rst_any |=> $stable(count_q))
    else $error("count moved without edge");

  a_cascade_gate: assert property (
    !smp.level[PIN_EN] && !rst_any |=> $stable(count_q))
    else $error("count moved with enable pin low");

  a_sat_holds: assert property (
    step && !ctrl_down_q && !rst_any && count_q == CNT_MAX
    |=> count_q == CNT_MAX)
    else $error("up count wrapped");

  a_rdata_idle: assert property (
    !rd |=> rdata_q == '0)
    else $error("read data outside read cycle");

  a_rdata_count: assert property (
    rd && addr == OFS_COUNT |=> rdata_q[CNT_W-1:0] == $past(count_q))
    else $error("count read wrong");

  a_term_irq: assert property (
    term_ev |=> irq_stat_q[IRQ_TERM_BIT])
    else $error("terminal event not latched");

  a_rst_irq: assert property (
    rst_any |=> irq_stat_q[IRQ_RST_BIT])
    else $error("reset event not latched");
endmodule

/* File: dv/pin_driver.sv */
module pin_driver (
  input wire logic clk,
  output logic clk_pin,
  output logic en_pin,
  output logic rst_pin,
  output logic clr_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    clk_pin = 1'b0;
    en_pin = 1'b1;
    rst_pin = 1'b0;
    clr_pin = 1'b0;
  end

  // High and low each four cycles so the input filter sees every level
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      clk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      clk_pin <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask

  // Level change, then time for filters and a cascaded stage to follow
  task automatic hold(input int sel, input logic v);
    @(posedge clk);
    case (sel)
      0: en_pin <= v;
      1: rst_pin <= v;
      default: clr_pin <= v;
    endcase
    repeat (12) @(posedge clk);
  endtask
endmodule

/* File: dv/tb_top.sv */
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end

module tb_top
  import cnt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [31:0] TGT = 32'h0000_0005;
  logic clk, arst_n, wr, rd, clk_pin, en_pin, rst_pin, clr_pin;
  logic overflow, carry, irq;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [31:0] count, count2, count3;
  logic overflow2, carry2, irq2, overflow3, carry3, irq3, bus3_off;
  logic [DATA_W-1:0] rdata2, rdata3;
  int err_total, n_tests;

  pin_driver u_pins (.clk(clk), .clk_pin(clk_pin), .en_pin(en_pin),
    .rst_pin(rst_pin), .clr_pin(clr_pin));

  event_counter #(.TARGET_RST(TGT)) u_dut (.clk(clk), .arst_n(arst_n),
    .cnt_clk_in(clk_pin), .cnt_en_in(en_pin), .cnt_rst_in(rst_pin),
    .cnt_clr_in(clr_pin), .count(count), .overflow(overflow),
    .carry(carry), .irq(irq), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  // Second stage enabled by the first stage's carry
  event_counter #(.TARGET_RST(TGT)) u_dut2 (.clk(clk), .arst_n(arst_n),
    .cnt_clk_in(clk_pin), .cnt_en_in(carry),
    .cnt_rst_in(rst_pin), .cnt_clr_in(clr_pin), .count(count2),
    .overflow(overflow2), .carry(carry2), .irq(irq2), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata2));

  // Third stage counts rising edges of the first-stage carry on its clock pin
  event_counter #(.TARGET_RST(TGT)) u_dut3 (.clk(clk), .arst_n(arst_n),
    .cnt_clk_in(carry), .cnt_en_in(1'b1),
    .cnt_rst_in(rst_pin), .cnt_clr_in(clr_pin), .count(count3),
    .overflow(overflow3), .carry(carry3), .irq(irq3), .addr(addr),
    .wdata(wdata), .wr(bus3_off), .rd(bus3_off), .rdata(rdata3));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask

  task automatic chk_out(input logic [31:0] c, input logic o,
                         input logic k, input logic [31:0] c2);
    #1;
    `CHK(count, c)
    `CHK(overflow, o)
    `CHK(carry, k)
    `CHK(count2, c2)
  endtask

  task automatic t_reset();
    chk_out(32'h0, 1'b0, 1'b0, 32'h0);
    rd_chk(OFS_CTRL, 32'h1);
    rd_chk(OFS_TARGET, TGT);
    rd_chk(8'h18, 32'h0);
  endtask

  task automatic t_up();
    u_pins.pulse(4);
    chk_out(32'h4, 1'b0, 1'b0, 32'h0);
    u_pins.pulse(1);
    chk_out(TGT, 1'b1, 1'b1, 32'h0);
    rd_chk(OFS_STATUS, 32'h7);
    wr_reg(OFS_IRQ_MASK, 32'h1);
    #1 `CHK(irq, 1'b1)
    wr_reg(OFS_IRQ_STAT, 32'h1);
    #1 `CHK(irq, 1'b0)
  endtask

  task automatic t_freeze();
    u_pins.hold(0, 1'b0);
    chk_out(TGT, 1'b1, 1'b0, 32'h0);
    `CHK(count3, 32'h1)
    u_pins.pulse(2);
    chk_out(TGT, 1'b1, 1'b0, 32'h0);
    u_pins.hold(0, 1'b1);
    u_pins.pulse(1);
    chk_out(32'h6, 1'b1, 1'b0, 32'h1);
    `CHK(count3, 32'h2)
    `CHK(overflow2, 1'b0)
    u_pins.hold(2, 1'b1);
    u_pins.hold(2, 1'b0);
    chk_out(32'h6, 1'b0, 1'b0, 32'h1);
  endtask

  task automatic t_reload();
    u_pins.hold(1, 1'b1);
    chk_out(32'h0, 1'b0, 1'b0, 32'h0);
    u_pins.hold(1, 1'b0);
  endtask

  task automatic t_down();
    wr_reg(OFS_CTRL, 32'h3);
    u_pins.hold(1, 1'b1);
    u_pins.hold(1, 1'b0);
    chk_out(TGT, 1'b0, 1'b0, TGT);
    u_pins.pulse(5);
    chk_out(32'h0, 1'b1, 1'b1, TGT);
    u_pins.pulse(1);
    chk_out(32'h0, 1'b1, 1'b1, 32'h4);
    wr_reg(OFS_CTRL, 32'h7);
    repeat (2) @(posedge clk);
    chk_out(TGT, 1'b0, 1'b0, TGT);
    rd_chk(OFS_COUNT, TGT);
    `CHK(rdata2, TGT)
  endtask

  initial begin
    err_total = 0;
    n_tests = 0;
    arst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    bus3_off = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    t_reset();
    t_up();
    t_freeze();
    t_reload();
    t_down();
    close_out();
  end

  // Whole run needs under a thousand cycles
  initial begin
    repeat (4000) @(posedge clk);
    err_total++;
    close_out();
  end
endmodule
